/* design/rofm_regs.sv */
// rofm_regs: rail enable override, output pin level and fault mask bank.
// assumes a synchronous byte register port from the serial host decoder
// and rail request, power-good tree and fault inputs from on-chip logic.
// factory options arrive as parameters; registers reset to them.
// no synchronisers: every input is on the same clock.
//
// Behaviour
// RULE_01: software level bit drives configured output pin
// RULE_02: unconfigured pin follows power-good tree, bit zero
// RULE_03: pins one-three open-drain/push-pull, four open-drain
// RULE_04: force bit zero: pin or power-good controls
// RULE_05: bit 3 forces termination on unless disabled
// RULE_06: bit 2 forces selected shared rail on
// RULE_07: bits 1, 0 force switch B1, linear A3
// RULE_08: A3 force holds regulator on when enabled
// RULE_09: mask bit one blocks fault shutdown
// RULE_10: first mask at A2h: A2, A1, step-downs
// RULE_11: second mask at A3h: A1, term, B2, B1, A3
// RULE_12: force/level register sits at A1h
// RULE_13: disable bit zero turns rail off
// RULE_14: host writes reserved bits 6=0, 5=1
// RULE_15: enable is (force or request) and disable
`timescale 1ns/1ps
module rofm_regs
    import rofm_pkg::*;
#(
    // factory options: software pins, push-pull pins, shared rail
    parameter logic [3:0] GPO_SW_CTRL      = 4'h0,
    parameter logic [3:0] GPO_PUSH_PULL    = 4'h0,
    parameter bit         SHARED_IS_SWITCH = 1'b0,
    // reset values of the chosen variant
    parameter logic [7:0] RST_FORCE_LEVEL  = ROFM_RST_FORCE_LEVEL,
    parameter logic [7:0] RST_FAULT_MASK1  = ROFM_RST_FAULT_MASK1,
    parameter logic [7:0] RST_FAULT_MASK2  = ROFM_RST_FAULT_MASK2
) (
    // clock and reset
    input  wire logic                      mclk_i,
    input  wire logic                      rstn_i,
    // register port
    input  wire logic [7:0]                reg_addr_i,
    input  wire logic [7:0]                reg_wdata_i,
    input  wire logic                      reg_wr_i,
    output logic [7:0]                     reg_rdata_o,
    // disable bits held elsewhere
    input  wire logic                      termination_disable_i,
    input  wire logic                      shared_rail_disable_i,
    input  wire logic                      switch_b1_disable_i,
    input  wire logic                      linear_a3_disable_i,
    // pin or power-good requests per rail
    input  wire logic [ROFM_NUM_EN-1:0]    rail_req_i,
    output logic [ROFM_NUM_EN-1:0]         rail_en_o,
    // output pins
    input  wire logic [3:0]                power_good_tree_i,
    output logic [3:0]                     out_pin_o,
    output logic [3:0]                     out_pin_oe_n_o,
    // faults and shutdown
    input  wire logic [ROFM_NUM_RAILS-1:0] rail_fault_i,
    output logic                           shutdown_req_o
);
    // stored registers
    logic [7:0] force_level_q;
    logic [7:0] fault_mask1_q;
    logic [7:0] fault_mask2_q;
    // output flops
    logic [7:0] rdata_q;
    logic [ROFM_NUM_EN-1:0] rail_en_q;
    // pin drive flops
    logic [3:0] pin_q;
    logic [3:0] pin_oe_n_q;
    logic       shutdown_q;

    // address decode
    // exact offset match on the live address
    // RULE_12: force register address
    wire logic sel_force = (reg_addr_i == ROFM_OFS_FORCE_LEVEL);
    // RULE_10: first mask address
    wire logic sel_mask1 = (reg_addr_i == ROFM_OFS_FAULT_MASK1);
    // RULE_11: second mask address
    wire logic sel_mask2 = (reg_addr_i == ROFM_OFS_FAULT_MASK2);

    // write masks, applied before the store
    // RULE_02: unused level bits stick at zero
    wire logic [7:0] force_wmask = {GPO_SW_CTRL, 4'hf};
    wire logic [7:0] force_d = reg_wdata_i & force_wmask;
    // RULE_11: top bit read-only zero
    wire logic [7:0] mask2_d = reg_wdata_i & ROFM_MASK2_WR_BITS;

    // register writes
    // one byte per strobe; each offset owns one register.
    // level bits of pins left to their trees never store a one,
    // so a read shows what the pin really follows
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            force_level_q <= RST_FORCE_LEVEL & {GPO_SW_CTRL, 4'hf};
            fault_mask1_q <= RST_FAULT_MASK1;
            fault_mask2_q <= RST_FAULT_MASK2 & ROFM_MASK2_WR_BITS;
        end else if (reg_wr_i) begin
            if (sel_force) begin
                force_level_q <= force_d;
            end
            if (sel_mask1) begin
                fault_mask1_q <= reg_wdata_i;
            end
            if (sel_mask2) begin
                fault_mask2_q <= mask2_d;
            end
        end
    end

    // read mux, unmapped reads zero
    // registered below: data trails the address by one edge,
    // so the host holds the address a cycle to read it
    wire logic [7:0] rdata_d = sel_force ? force_level_q :
                               sel_mask1 ? fault_mask1_q :
                               sel_mask2 ? fault_mask2_q : 8'h00;

    // rail force bits
    wire logic f_a3   = force_level_q[ROFM_BIT_LINEAR_A3_FORCE];
    wire logic f_b1   = force_level_q[ROFM_BIT_SWITCH_B1_FORCE];
    wire logic f_sh   = force_level_q[ROFM_BIT_SHARED_FORCE];
    wire logic f_term = force_level_q[ROFM_BIT_TERMINATION_FORCE];
    // the shared force reaches only the rail picked at build time;
    // the other one sees no force and a constant disable of one
    // RULE_06: shared force routed by factory select
    wire logic f_b2 = SHARED_IS_SWITCH ? f_sh : 1'b0;
    wire logic f_a1 = SHARED_IS_SWITCH ? 1'b0 : f_sh;
    wire logic dis_b2 = SHARED_IS_SWITCH ? shared_rail_disable_i : 1'b1;
    wire logic dis_a1 = SHARED_IS_SWITCH ? 1'b1 : shared_rail_disable_i;

    // rail enables
    // RULE_15: or request, and disable
    // RULE_04: request alone when force zero
    // RULE_13: disable zero forces off
    // RULE_07: switch b1 and linear a3 forces
    // RULE_08: a3 held on while enabled
    // a disable bit at zero beats both force and request,
    // so software can turn off every rail except the unselected shared one
    // linear a3: own disable bit
    wire logic en_a3 = (f_a3 | rail_req_i[ROFM_EN_LINEAR_A3]) &
                       linear_a3_disable_i;
    // switch b1: own disable bit
    wire logic en_b1 = (f_b1 | rail_req_i[ROFM_EN_SWITCH_B1]) &
                       switch_b1_disable_i;
    // switch b2: shared force only when selected
    wire logic en_b2 = (f_b2 | rail_req_i[ROFM_EN_SWITCH_B2]) & dis_b2;
    // RULE_05: termination force
    wire logic en_term = (f_term | rail_req_i[ROFM_EN_TERMINATION]) &
                         termination_disable_i;
    // linear a1: shared force only when selected
    wire logic en_a1 = (f_a1 | rail_req_i[ROFM_EN_LINEAR_A1]) & dis_a1;
    // gather in output order
    wire logic [ROFM_NUM_EN-1:0] rail_en_d = {
        en_a1, en_term, en_b2, en_b1, en_a3
    };

    // output pin drive, per pin
    // push-pull drives the level with the enable held low;
    // open-drain only pulls low and releases for a one.
    // pin four has no push-pull driver, whatever the option says
    logic [3:0] pin_d;
    logic [3:0] pin_oe_n_d;
    genvar g;
    generate
        for (g = 0; g < ROFM_NUM_OUT_PINS; g++) begin : g_pin
            // RULE_01: level bit when software controlled
            // RULE_02: else power-good tree
            wire logic lvl = GPO_SW_CTRL[g] ?
                force_level_q[ROFM_BIT_OUT_LEVEL_LO + g] :
                power_good_tree_i[g];
            // RULE_03: last pin open-drain only
            wire logic pp = GPO_PUSH_PULL[g] && (g != ROFM_OD_ONLY_PIN);
            assign pin_d[g]      = pp ? lvl : 1'b0;
            assign pin_oe_n_d[g] = pp ? 1'b0 : lvl; // od: release on one
        end
    endgenerate

    // fault shutdown
    // lower eight faults pair with the first mask, upper five with
    // the second; reserved mask bits never reach the fault tree.
    // shutdown is a level: it stays up while the fault stands
    // RULE_09: masked faults ignored
    wire logic [ROFM_NUM_RAILS-1:0] fault_mask = {
        fault_mask2_q[ROFM_NUM_RAILS_MASK2-1:0], fault_mask1_q};
    wire logic shutdown_d = |(rail_fault_i & ~fault_mask);

    // output flops: every output one edge behind its inputs
    // read data flop
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // rail and shutdown flops, rails off in reset
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rail_en_q  <= '0;
            shutdown_q <= 1'b0;
        end else begin
            rail_en_q  <= rail_en_d;
            shutdown_q <= shutdown_d;
        end
    end

    // pin flops, pins released in reset
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_q      <= 4'h0;
            pin_oe_n_q <= 4'hf;
        end else begin
            pin_q      <= pin_d;
            pin_oe_n_q <= pin_oe_n_d;
        end
    end

    // ports straight from the output flops
    assign reg_rdata_o    = rdata_q;
    assign rail_en_o      = rail_en_q;
    assign out_pin_o      = pin_q;
    assign out_pin_oe_n_o = pin_oe_n_q;
    assign shutdown_req_o = shutdown_q;
endmodule

/* design/rofm_pkg.sv */
// rofm_pkg: register offsets, field positions and reset values for the
// rail override / fault mask register bank.
// assumes a byte-wide register port fed by the serial host decoder.
package rofm_pkg;
    // register offsets in the device map
    localparam logic [7:0] ROFM_OFS_FORCE_LEVEL = 8'ha1;
    localparam logic [7:0] ROFM_OFS_FAULT_MASK1 = 8'ha2;
    localparam logic [7:0] ROFM_OFS_FAULT_MASK2 = 8'ha3;

    // force/level register fields
    localparam int ROFM_BIT_LINEAR_A3_FORCE   = 0;
    localparam int ROFM_BIT_SWITCH_B1_FORCE   = 1;
    localparam int ROFM_BIT_SHARED_FORCE      = 2;
    localparam int ROFM_BIT_TERMINATION_FORCE = 3;
    localparam int ROFM_BIT_OUT_LEVEL_LO      = 4;
    localparam int ROFM_NUM_OUT_PINS          = 4;
    localparam int ROFM_OD_ONLY_PIN           = 3;

    // fault mask fields (rail index order of the fault inputs)
    localparam int ROFM_NUM_RAILS_MASK1 = 8;
    localparam int ROFM_NUM_RAILS_MASK2 = 5;
    localparam int ROFM_NUM_RAILS       = 13;
    localparam int ROFM_BIT_RSVD_ZERO   = 6;
    localparam int ROFM_BIT_RSVD_ONE    = 5;
    localparam int ROFM_BIT_RSVD_RO     = 7;

    // rail enable output order: a3, b1, b2, termination, a1
    localparam int ROFM_EN_LINEAR_A3   = 0;
    localparam int ROFM_EN_SWITCH_B1   = 1;
    localparam int ROFM_EN_SWITCH_B2   = 2;
    localparam int ROFM_EN_TERMINATION = 3;
    localparam int ROFM_EN_LINEAR_A1   = 4;
    localparam int ROFM_NUM_EN         = 5;

    // reset values of the factory variant used by default
    localparam logic [7:0] ROFM_RST_FORCE_LEVEL = 8'h01;
    localparam logic [7:0] ROFM_RST_FAULT_MASK1 = 8'hc0;
    localparam logic [7:0] ROFM_RST_FAULT_MASK2 = 8'h27;
    localparam logic [7:0] ROFM_MASK2_WR_BITS   = 8'h7f;
endpackage

/* bench/rofm_checker.sv */
// rofm_checker: port properties of the rail override register bank.
// assumes the shared force goes to linear a1 (default choice).
`timescale 1ns/1ps
module rofm_checker
    import rofm_pkg::*;
(
    // clock, reset and register port
    input wire logic        mclk_i,
    input wire logic        rstn_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic [7:0]  reg_rdata_o,
    // rails, pins and faults
    input wire logic        termination_disable_i,
    input wire logic        linear_a3_disable_i,
    input wire logic [4:0]  rail_req_i,
    input wire logic [4:0]  rail_en_o,
    input wire logic [3:0]  out_pin_o,
    input wire logic [12:0] rail_fault_i,
    input wire logic        shutdown_req_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // a3 force written, a3 left enabled for two edges
    sequence a3_forced;
        reg_wr_i && reg_addr_i == ROFM_OFS_FORCE_LEVEL && reg_wdata_i[0]
        ##1 linear_a3_disable_i [*2];
    endsequence
    a3_force_a: assert property (a3_forced |-> rail_en_o[0])
        else $error("linear a3 force ignored");
    term_off_a: assert property (
        !$past(termination_disable_i) |-> !rail_en_o[3])
        else $error("termination on while disabled");
    term_request_a: assert property (
        $past(rstn_i && rail_req_i[3] && termination_disable_i)
        |-> rail_en_o[3]) else $error("termination request lost");
    b2_follow_a: assert property (
        $past(rstn_i) |-> rail_en_o[2] == $past(rail_req_i[2]))
        else $error("switch b2 not following its request");
    fault_quiet_a: assert property (
        $past(rail_fault_i) == 13'h0 |-> !shutdown_req_o)
        else $error("shutdown without a fault");
    unmapped_read_a: assert property (
        !($past(reg_addr_i) inside {[8'ha1:8'ha3]}) |-> reg_rdata_o == 8'h00)
        else $error("unmapped address read not zero");
    mask2_bit7_a: assert property (
        $past(reg_addr_i) == ROFM_OFS_FAULT_MASK2 |-> !reg_rdata_o[7])
        else $error("second mask bit 7 reads one");
    pin4_od_a: assert property (out_pin_o[3] == 1'b0)
        else $error("pin four driven high");
endmodule
bind rofm_regs rofm_checker chk_u (.*);

/* bench/rofm_host.sv */
// rofm_host: host model driving the bank's byte register port.
// assumes requests are taken on the rising clock edge.
`timescale 1ns/1ps
module rofm_host
    import rofm_pkg::*;
(
    // clock and read data
    input wire logic  mclk_i,
    input wire logic [7:0] rdata_i,
    // register request
    output logic [7:0] addr_o = 8'h00,
    output logic [7:0] wdata_o = 8'h00,
    output logic       wr_o = 1'b0
);
    // one byte access; q holds the read data of address a
    task automatic xfer(input logic [7:0] a, d, input logic w,
                        output logic [7:0] q);
        @(posedge mclk_i);
        addr_o <= a;
        wdata_o <= (a == ROFM_OFS_FAULT_MASK2) ? {d[7], 2'b01, d[4:0]} : d;
        wr_o <= w;
        @(posedge mclk_i);
        wr_o <= 1'b0;
        @(negedge mclk_i);
        q = rdata_i;
    endtask
endmodule

/* bench/rofm_regs_tb.sv */
// rofm_regs_tb: random and corner traffic through the register bank.
// assumes the host model owns the register port; 20 MHz clock.
`timescale 1ns/1ps
module rofm_regs_tb;
    import rofm_pkg::*;
    localparam logic [3:0] SW = 4'hd;
    localparam logic [3:0] PP = 4'h9;
    logic        mclk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        wr, sd;
    logic [7:0]  addr, wdata, rdata, q, f, m1, m2;
    logic [3:0]  dis = 4'h0, pg = 4'h0, pin, oen;
    logic [4:0]  req = 5'h0, en;
    logic [12:0] flt = 13'h0;
    logic [31:0] seed = 32'h74565d6a;
    int          miscompares = 0;
    int          comparisons = 0;
    // clock with 50 ns period
    always #25 mclk_i = ~mclk_i;
    rofm_host host_u (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr),
        .wdata_o(wdata), .wr_o(wr));
    rofm_regs #(.GPO_SW_CTRL(SW), .GPO_PUSH_PULL(PP)) dut_u (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rdata_o(rdata),
        .termination_disable_i(dis[0]), .shared_rail_disable_i(dis[1]),
        .switch_b1_disable_i(dis[2]), .linear_a3_disable_i(dis[3]),
        .rail_req_i(req), .rail_en_o(en), .power_good_tree_i(pg),
        .out_pin_o(pin), .out_pin_oe_n_o(oen), .rail_fault_i(flt),
        .shutdown_req_o(sd));
    // xorshift step
    function automatic logic [31:0] nxt(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    // expected enables, pin drive, pin enables and shutdown
    function automatic logic [15:0] exp_out();
        logic [3:0] v;
        v = (SW & f[7:4]) | (~SW & pg);
        return {2'h0, (f[2] | req[4]) & dis[1], (f[3] | req[3]) & dis[0],
            req[2], (f[1] | req[1]) & dis[2], (f[0] | req[0]) & dis[3],
            v & PP & 4'h7, v & ~(PP & 4'h7), |(flt & ~{m2[4:0], m1})};
    endfunction
    task automatic check(input string n, input logic [15:0] s, e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, e);
        host_u.xfer(a, 8'h00, 1'b0, q);
        check(n, {8'h00, q}, {8'h00, e});
    endtask
    task automatic stop_test();
        $display("miscompares %0d comparisons %0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // reset values first, then random writes with corner inputs
    initial begin
        f = ROFM_RST_FORCE_LEVEL;
        m1 = ROFM_RST_FAULT_MASK1;
        m2 = ROFM_RST_FAULT_MASK2;
        repeat (5) @(posedge mclk_i);
        rstn_i <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            seed = nxt(seed);
            if (i > 0) begin
                f = seed[7:0] & {SW, 4'hf};
                m1 = seed[15:8];
                m2 = {3'b001, seed[20:16]};
                host_u.xfer(ROFM_OFS_FORCE_LEVEL, seed[7:0], 1'b1, q);
                host_u.xfer(ROFM_OFS_FAULT_MASK1, m1, 1'b1, q);
                host_u.xfer(ROFM_OFS_FAULT_MASK2, seed[23:16], 1'b1, q);
            end
            seed = nxt(seed);
            @(posedge mclk_i);
            {dis, req, pg, flt} <= (i % 8 == 1) ? '1 :
                (i % 8 == 2) ? '0 : seed[25:0];
            repeat (2) @(posedge mclk_i);
            @(negedge mclk_i);
            check("outputs", {2'h0, en, pin, oen, sd}, exp_out());
            rdchk("force_level", ROFM_OFS_FORCE_LEVEL, f);
            rdchk("mask1", ROFM_OFS_FAULT_MASK1, m1);
            rdchk("mask2", ROFM_OFS_FAULT_MASK2, m2);
            rdchk("unmapped", 8'ha0 + {i[0], 2'b00}, 8'h00);
        end
        stop_test();
    end
endmodule
